/* File: common/dod_defines.svh */
`ifndef DOD_DEFINES_SVH
`define DOD_DEFINES_SVH
// Register word indices on the Avalon-MM slave
`define DOD_REG_CTRL 2'h0
`define DOD_REG_STATUS 2'h1
`define DOD_REG_COUNT 2'h2
`define DOD_REG_LAST 2'h3
// Control register fields
`define DOD_CTRL_ENABLE 0
`define DOD_CTRL_XF_CLR 1
`define DOD_CTRL_RESET 1'b1
// Status register fields
`define DOD_STAT_XF 0
`define DOD_STAT_BUSY 1
`define DOD_STAT_WAIT2 2
// Cycle counts of the instructions
`define DOD_CYC_ONE 3'h1
`define DOD_CYC_TWO 3'h2
`define DOD_CYC_RET 3'h4
`define DOD_CYC_NORET 3'h2
`endif

/* File: common/dod_pkg.sv */
package dod_pkg;
  // Decoded operation codes
  typedef enum logic [4:0] {
    DOD_OP_NONE = 5'b00000,
    DOD_OP_POP_ACC = 5'b00001,
    DOD_OP_POP_MEM = 5'b00010,
    DOD_OP_PUSH_MEM = 5'b00011,
    DOD_OP_PUSH_ACC = 5'b00100,
    DOD_OP_RET = 5'b00101,
    DOD_OP_RET_COND = 5'b00110,
    DOD_OP_RPT_MEM = 5'b00111,
    DOD_OP_RPT_IMM = 5'b01000,
    DOD_OP_STORE_HI = 5'b01001,
    DOD_OP_STORE_LO = 5'b01010,
    DOD_OP_AUX_SUB = 5'b01011,
    DOD_OP_SET_STAT = 5'b01100,
    DOD_OP_SET_XF = 5'b01101,
    DOD_OP_SUB_PROD = 5'b01110,
    DOD_OP_SQR_SUB = 5'b01111,
    DOD_OP_ST_STAT_A = 5'b10000,
    DOD_OP_ST_STAT_B = 5'b10001,
    DOD_OP_STORE_LONG = 5'b10010,
    DOD_OP_SUB_LONG = 5'b10011,
    DOD_OP_SUB_SHORT = 5'b10100,
    DOD_OP_SUB_SHIFT = 5'b10101,
    DOD_OP_SUB_TSHIFT = 5'b10110,
    DOD_OP_SUB_LOW_NSX = 5'b10111,
    DOD_OP_XOR_LONG = 5'b11000,
    DOD_OP_XOR_LONG16 = 5'b11001,
    DOD_OP_ZERO_LOAD_RND = 5'b11010,
    DOD_OP_OTHER = 5'b11111
  } dod_op_e;

  // Status bit chosen by a set operation
  typedef enum logic [2:0] {
    DOD_ST_NONE = 3'b000,
    DOD_ST_CARRY = 3'b001,
    DOD_ST_BLOCK_PROG = 3'b010,
    DOD_ST_INT_DIS = 3'b011,
    DOD_ST_OVF_MODE = 3'b100,
    DOD_ST_TEST_CTRL = 3'b101,
    DOD_ST_SIGN_EXT = 3'b110
  } dod_stat_e;

  // Whole state of the decoder
  typedef struct packed {
    logic enable;
    logic xf;
    logic wait2;
    logic [2:0] busy;
    dod_op_e hold_op;
    logic [7:0] hold_addr;
    logic [3:0] hold_shift;
    logic op_valid;
    dod_op_e op;
    dod_stat_e stat_sel;
    logic [7:0] addr;
    logic [3:0] shift;
    logic [15:0] imm;
    logic [3:0] cond;
    logic [2:0] words;
    logic [2:0] cycles;
    logic [15:0] count;
    logic ack;
    logic [31:0] rdata;
  } dod_state_s;
endpackage : dod_pkg

/* File: logic/dod_decoder.sv */
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "dod_defines.svh"
// Contract
// - BE32 pops stack to low accumulator
// - 8A pops stack to addressed memory
// - 76 pushes addressed memory word onto stack
// - BE3C pushes low accumulator onto stack
// - return four cycles; conditional four or two
// - 0B loads repeat count from memory
// - BB loads repeat count from immediate
// - 9x stores shifted accumulator half, bit11 selects
// - 7C subtracts short immediate from aux register
// - BE4x sets status bit by low nibble
// - BE4D drives external flag high
// - BE05 subtracts product from accumulator
// - 53 squares and subtracts previous product
// - 8E and 8F store status registers
// - AE stores following constant, two cycles
// - BFAx subtracts shifted constant, two cycles
// - BA subtracts short immediate from accumulator
// - 3x subtracts shifted memory word
// - 67 subtracts word shifted by multiplicand
// - 66 subtracts low without sign extension
// - BFDx and BE83 xor shifted constant
// - 68 zeroes low, loads high rounded
module dod_decoder (
  input wire logic mclk_i, // Core clock
  input wire logic nrst_i, // Async reset, active low
  // Fetch side
  input wire logic instr_valid_i, // Program word offered
  input wire logic [15:0] instr_i, // Program word
  output logic instr_ready_o, // Decoder can take a word this edge
  input wire logic cond_met_i, // Return condition true
  // Decode outputs
  output logic op_valid_o, // One-cycle decode strobe
  output dod_pkg::dod_op_e op_o, // Decoded operation
  output dod_pkg::dod_stat_e stat_sel_o, // Status bit to set
  output logic [7:0] addr_byte_o, // Addressing byte
  output logic [3:0] shift_o, // Shift amount field
  output logic [15:0] imm_o, // Immediate or constant
  output logic [3:0] cond_o, // Return condition bits
  output logic [2:0] words_o, // Instruction words
  output logic [2:0] cycles_o, // Instruction cycles
  output logic external_flag_output_o, // External flag pin
  // Avalon-MM slave
  input wire logic [1:0] avs_address_i, // Word index
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o // Stall until answer
);
  import dod_pkg::*;

  dod_state_s st; // Registered state
  dod_state_s next_st; // Next state
  logic take; // Fetch word accepted
  logic bus_req; // Bus access pending
  logic bus_wr; // Write completes now
  dod_op_e dec_op; // First-word decode
  dod_stat_e dec_sel; // First-word status select
  logic dec_two; // Needs constant word
  logic [2:0] dec_cyc; // Cycles of first word

  // Fetch handshake, stalls while busy
  assign take = instr_valid_i & instr_ready_o;
  assign instr_ready_o = st.enable & (st.busy == 3'h0);

  // Bus answer one cycle after the request
  assign bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~st.ack;
  assign bus_wr = avs_write_i & st.ack;

  // Opcode pattern recognition of one program word
  always_comb begin
    dec_op = DOD_OP_OTHER;
    dec_sel = DOD_ST_NONE;
    dec_two = 1'b0;
    dec_cyc = `DOD_CYC_ONE;
    if (instr_i == 16'hbe32) begin
      dec_op = DOD_OP_POP_ACC;
    end else if (instr_i == 16'hbe3c) begin
      dec_op = DOD_OP_PUSH_ACC;
    end else if (instr_i == 16'hbe05) begin
      dec_op = DOD_OP_SUB_PROD;
    end else if (instr_i == 16'hbe4d) begin
      dec_op = DOD_OP_SET_XF;
    end else if (instr_i == 16'hbe83) begin
      dec_op = DOD_OP_XOR_LONG16;
      dec_two = 1'b1;
    end else if (instr_i[15:4] == 12'hbe4) begin
      // Status bit picked by the low nibble
      dec_op = DOD_OP_SET_STAT;
      case (instr_i[3:0])
        4'hf: dec_sel = DOD_ST_CARRY;
        4'h5: dec_sel = DOD_ST_BLOCK_PROG;
        4'h1: dec_sel = DOD_ST_INT_DIS;
        4'h3: dec_sel = DOD_ST_OVF_MODE;
        4'hb: dec_sel = DOD_ST_TEST_CTRL;
        4'h7: dec_sel = DOD_ST_SIGN_EXT;
        default: dec_op = DOD_OP_OTHER; // Not a set op
      endcase
    end else if (instr_i[15:4] == 12'hbfa) begin
      dec_op = DOD_OP_SUB_LONG;
      dec_two = 1'b1;
    end else if (instr_i[15:4] == 12'hbfd) begin
      dec_op = DOD_OP_XOR_LONG;
      dec_two = 1'b1;
    end else if (instr_i == 16'hef00) begin
      dec_op = DOD_OP_RET;
      dec_cyc = `DOD_CYC_RET;
    end else if (instr_i[15:10] == 6'b111011) begin
      // Taken return costs four, else two
      dec_op = DOD_OP_RET_COND;
      dec_cyc = cond_met_i ? `DOD_CYC_RET : `DOD_CYC_NORET;
    end else if (instr_i[15:12] == 4'h9) begin
      // Bit 11 picks the accumulator half
      dec_op = instr_i[11] ? DOD_OP_STORE_HI
                           : DOD_OP_STORE_LO;
    end else if (instr_i[15:12] == 4'h3) begin
      dec_op = DOD_OP_SUB_SHIFT;
    end else begin
      // Whole upper byte selects the rest
      case (instr_i[15:8])
        8'h8a: dec_op = DOD_OP_POP_MEM;
        8'h76: dec_op = DOD_OP_PUSH_MEM;
        8'h0b: dec_op = DOD_OP_RPT_MEM;
        8'hbb: dec_op = DOD_OP_RPT_IMM;
        8'h7c: dec_op = DOD_OP_AUX_SUB;
        8'h53: dec_op = DOD_OP_SQR_SUB;
        8'h8e: dec_op = DOD_OP_ST_STAT_A;
        8'h8f: dec_op = DOD_OP_ST_STAT_B;
        8'hba: dec_op = DOD_OP_SUB_SHORT;
        8'h67: dec_op = DOD_OP_SUB_TSHIFT;
        8'h66: dec_op = DOD_OP_SUB_LOW_NSX;
        8'h68: dec_op = DOD_OP_ZERO_LOAD_RND;
        8'hae: begin
          dec_op = DOD_OP_STORE_LONG;
          dec_two = 1'b1;
        end
        default: dec_op = DOD_OP_OTHER; // Outside this range
      endcase
    end
  end

  // Next-state logic of decoder and bus slave
  always_comb begin
    next_st = st;
    next_st.op_valid = 1'b0;
    // Count down extra cycles of long instructions
    if (st.busy != 3'h0) begin
      next_st.busy = st.busy - 3'h1;
    end
    if (take && st.wait2) begin
      // Second word is the 16-bit constant
      next_st.wait2 = 1'b0;
      next_st.op_valid = 1'b1;
      next_st.op = st.hold_op;
      next_st.addr = st.hold_addr;
      next_st.shift = st.hold_shift;
      next_st.imm = instr_i;
      next_st.words = `DOD_CYC_TWO;
      next_st.cycles = `DOD_CYC_TWO;
      next_st.count = st.count + 16'h1;
    end else if (take && dec_two) begin
      // Hold first word, wait for constant
      next_st.wait2 = 1'b1;
      next_st.hold_op = dec_op;
      next_st.hold_addr = instr_i[7:0];
      // Shift amount from the low nibble of the first word
      next_st.hold_shift = instr_i[3:0];
    end else if (take) begin
      // Single-word instruction issues now
      next_st.op_valid = 1'b1;
      next_st.op = dec_op;
      next_st.stat_sel = dec_sel;
      next_st.addr = instr_i[7:0];
      next_st.imm = {8'h00, instr_i[7:0]};
      next_st.cond = instr_i[3:0];
      next_st.words = `DOD_CYC_ONE;
      next_st.cycles = dec_cyc;
      next_st.busy = dec_cyc - 3'h1;
      next_st.count = st.count + 16'h1;
      // Shift field width depends on format
      if (dec_op == DOD_OP_STORE_HI || dec_op == DOD_OP_STORE_LO) begin
        next_st.shift = {1'b0, instr_i[10:8]};
      end else begin
        next_st.shift = instr_i[11:8];
      end
    end
    // Bus access answered one cycle later
    next_st.ack = bus_req & ~st.ack;
    if (bus_req && !st.ack) begin
      case (avs_address_i)
        `DOD_REG_CTRL: next_st.rdata = {31'h0, st.enable};
        `DOD_REG_STATUS: next_st.rdata = {29'h0, st.wait2,
                           (st.busy != 3'h0), st.xf};
        `DOD_REG_COUNT: next_st.rdata = {16'h0, st.count};
        `DOD_REG_LAST: next_st.rdata = {27'h0, st.op};
        default: next_st.rdata = 32'h0; // Unmapped
      endcase
    end
    // Software control; clear loses to a set below
    if (bus_wr && avs_address_i == `DOD_REG_CTRL) begin
      next_st.enable = avs_writedata_i[`DOD_CTRL_ENABLE];
      if (avs_writedata_i[`DOD_CTRL_XF_CLR]) begin
        next_st.xf = 1'b0;
      end
    end
    // External flag set wins over a clear
    if (take && !st.wait2 && dec_op == DOD_OP_SET_XF) begin
      next_st.xf = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.enable <= `DOD_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign op_valid_o = st.op_valid;
  assign op_o = st.op;
  assign stat_sel_o = st.stat_sel;
  assign addr_byte_o = st.addr;
  assign shift_o = st.shift;
  assign imm_o = st.imm;
  assign cond_o = st.cond;
  assign words_o = st.words;
  assign cycles_o = st.cycles;
  assign external_flag_output_o = st.xf;
  assign avs_readdata_o = st.rdata;
endmodule : dod_decoder

/* File: verif/dod_fetch_model.sv */
`timescale 1ns/1ps
// Fetch unit model offering program words
module dod_fetch_model (
  input wire logic mclk_i, // Core clock
  input wire logic ready_i, // Decoder takes word
  output logic valid_o, // Word offered
  output logic [15:0] word_o, // Program word
  output logic cond_o // Return condition
);
  // Idle at start
  initial begin
    valid_o = 1'b0;
    word_o = 16'h0;
    cond_o = 1'b0;
  end
  // Offer one word at a rising edge, hold it until taken
  task automatic send(input logic [15:0] w, input logic c);
    @(posedge mclk_i);
    valid_o <= 1'b1;
    word_o <= w;
    cond_o <= c;
    // Ready is read before the edge's updates land
    do begin
      @(posedge mclk_i);
    end while (ready_i !== 1'b1);
    valid_o <= 1'b0;
    // Released line shows inverse, not stale word
    word_o <= ~w;
  endtask : send
endmodule : dod_fetch_model

/* File: verif/dod_decoder_assertions.sv */
`timescale 1ns/1ps
// Port checker for the decoder
module dod_chk (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_ready_o,
  input wire logic cond_met_i,
  input wire logic op_valid_o,
  input wire dod_pkg::dod_op_e op_o,
  input wire logic [7:0] addr_byte_o,
  input wire logic [3:0] shift_o,
  input wire logic [15:0] imm_o,
  input wire logic [2:0] words_o,
  input wire logic [2:0] cycles_o,
  input wire logic external_flag_output_o
);
  import dod_pkg::*;
  logic tk; // Word taken this edge
  logic two; // First word of a two-word op
  logic cst; // Constant word expected next
  logic nw; // Taken word is an opcode
  assign tk = instr_valid_i && instr_ready_o;
  assign nw = tk && !cst;
  assign two = instr_i[15:8] == 8'hae || instr_i[15:4] == 12'hbfa
    || instr_i[15:4] == 12'hbfd || instr_i == 16'hbe83;
  // Track pairing of opcode and constant
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) cst <= 1'b0;
    else if (tk) cst <= !cst && two;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  property p_addr;
    nw && instr_i[15:8] == 8'h8a |=> op_o == DOD_OP_POP_MEM
      && addr_byte_o == $past(instr_i[7:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("pop addr");
  property p_ret;
    nw && instr_i == 16'hef00 |=> cycles_o == 3'h4 ##0
      (!instr_ready_o) [*3] ##1 instr_ready_o;
  endproperty
  a_ret: assert property (p_ret) else $error("return stall");
  property p_conditional_return;
    nw && instr_i[15:10] == 6'h3b && instr_i != 16'hef00 |=>
      cycles_o == ($past(cond_met_i) ? 3'h4 : 3'h2);
  endproperty
  a_conditional_return: assert property (p_conditional_return) else $error("conditional_return cycles");
  property p_xf;
    nw && instr_i == 16'hbe4d |=> external_flag_output_o;
  endproperty
  a_xf: assert property (p_xf) else $error("flag not set");
  property p_store;
    nw && instr_i[15:12] == 4'h9 |=> shift_o == {1'b0, $past(instr_i[10:8])}
      && op_o == ($past(instr_i[11]) ? DOD_OP_STORE_HI : DOD_OP_STORE_LO);
  endproperty
  a_store: assert property (p_store) else $error("store half");
  property p_sub;
    nw && instr_i[15:12] == 4'h3 |=> op_o == DOD_OP_SUB_SHIFT
      && shift_o == $past(instr_i[11:8]);
  endproperty
  a_sub: assert property (p_sub) else $error("sub shift");
  property p_first;
    nw && two |=> !op_valid_o;
  endproperty
  a_first: assert property (p_first) else $error("early decode");
  property p_long;
    tk && cst |=> op_valid_o && words_o == 3'h2 && cycles_o == 3'h2
      && imm_o == $past(instr_i);
  endproperty
  a_long: assert property (p_long) else $error("long op");
endmodule : dod_chk

/* File: verif/test_dod_decoder.sv */
`timescale 1ns/1ps
module test_dod_decoder;
  import dod_pkg::*;
  logic mclk_i, nrst_i, ir, cm, ov, xf, ar, aw, wr, iv;
  logic [15:0] iw, im;
  dod_op_e op;
  dod_stat_e ss;
  logic [7:0] ab;
  logic [3:0] sh, co;
  logic [2:0] wd, cy;
  logic [1:0] aa;
  logic [31:0] ad, rd, d;
  int n_fail, samples_checked, cyc, n_dec;
  // Entry: {cond, cycles}, op, word
  logic [27:0] tb [22] = '{28'h101be32, 28'h1028a12, 28'h1037634,
    28'h104be3c, 28'h405ef00, 28'hc06ee11, 28'h206ee11,
    28'h1070b56, 28'h108bb78, 28'h1099d9a, 28'h10a949a,
    28'h10b7cbc, 28'h10dbe4d, 28'h10ebe05, 28'h10f5311,
    28'h1108e22, 28'h1118f33, 28'h114ba44, 28'h1153c55,
    28'h1166766, 28'h1176677, 28'h11a6888};
  logic [23:0] t2 [4] = '{24'h12ae05, 24'h13bfa3, 24'h18bfd2, 24'h19be83};
  logic [23:0] nb = 24'hf513b7; // Set-status nibbles in enum order
  dod_fetch_model u_f (.mclk_i(mclk_i), .ready_i(ir), .valid_o(iv),
    .word_o(iw), .cond_o(cm));
  dod_decoder DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .instr_valid_i(iv),
    .instr_i(iw), .instr_ready_o(ir), .cond_met_i(cm), .op_valid_o(ov),
    .op_o(op), .stat_sel_o(ss), .addr_byte_o(ab), .shift_o(sh), .imm_o(im),
    .cond_o(co), .words_o(wd), .cycles_o(cy), .external_flag_output_o(xf),
    .avs_address_i(aa), .avs_read_i(ar), .avs_write_i(aw),
    .avs_writedata_i(ad), .avs_readdata_o(rd), .avs_waitrequest_o(wr));
  task automatic test_done;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // Avalon access, held until waitrequest seen low
  task automatic acc(input logic [1:0] a, input logic w, input logic [31:0] v);
    @(posedge mclk_i);
    aa <= a;
    aw <= w;
    ar <= !w;
    ad <= v;
    // Waitrequest and read data seen at the rising edge itself
    do begin
      @(posedge mclk_i);
    end while (wr !== 1'b0);
    d = rd;
    aw <= 1'b0;
    ar <= 1'b0;
  endtask : acc
  // One-word decode and compare
  task automatic dec(input logic [27:0] t);
    u_f.send(t[15:0], t[27]);
    #1;
    n_dec++;
    chk("valid", ov, 1);
    chk("op", op, t[23:16]);
    chk("cycles", cy, t[26:24]);
    chk("words", wd, 1);
    chk("addr", ab, t[7:0]);
    chk("imm", im, t[7:0]);
    chk("cond", co, t[3:0]);
  endtask : dec
  // Clock and hang guard
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    nrst_i = 1'b0;
    {ar, aw, aa, ad} = '0;
    repeat (10) @(posedge mclk_i);
    nrst_i <= 1'b1;
    acc(2'h0, 1'b0, 32'h0);
    chk("ctrl", d, 1);
    foreach (tb[i]) dec(tb[i]);
    $display("test one_word done");
    for (int i = 0; i < 6; i++) begin
      dec({4'h1, 8'h0c, 12'hbe4, nb[23-4*i -: 4]});
      chk("stat", ss, i + 1);
    end
    $display("test status_set done");
    foreach (t2[i]) begin
      u_f.send(t2[i][15:0], 1'b0);
      #1;
      chk("first", ov, 0);
      u_f.send({i[3:0], 12'h5a7}, 1'b0);
      #1;
      n_dec++;
      chk("op2", op, t2[i][23:16]);
      chk("const", im, {i[3:0], 12'h5a7});
      chk("cyc2", {wd, cy}, 6'h12);
      chk("shift2", sh, t2[i][3:0]);
    end
    $display("test two_word done");
    chk("xf", xf, 1);
    acc(2'h0, 1'b1, 32'h3);
    acc(2'h1, 1'b0, 32'h0);
    chk("xf_stat", d[0], 0);
    chk("xf_clr", xf, 0);
    acc(2'h0, 1'b1, 32'h0);
    @(posedge mclk_i);
    #1;
    chk("ready_off", ir, 0);
    acc(2'h0, 1'b1, 32'h1);
    acc(2'h2, 1'b0, 32'h0);
    chk("count", d[15:0], n_dec[15:0]);
    $display("test registers done");
    test_done;
  end
endmodule : test_dod_decoder
bind dod_decoder dod_chk u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .instr_ready_o(instr_ready_o), .cond_met_i(cond_met_i),
  .op_valid_o(op_valid_o), .op_o(op_o), .addr_byte_o(addr_byte_o),
  .shift_o(shift_o), .imm_o(imm_o), .words_o(words_o), .cycles_o(cycles_o),
  .external_flag_output_o(external_flag_output_o));
